// [hw/ctrl_serial_port.sv]
/*
  Serial control port running on the host's serial clock.
  Assumes chip select is high while the system is in reset, the read image
  and device select are static during a frame, and chip select stays low
  at least 40 ns after the sixteenth rising edge.
*/
`timescale 1ns/1ns
`include "xcvr_mode_regs.svh"
module ctrl_serial_port
  import xcvr_mode_pkg::*;
(
  input wire logic ctrl_clk,
  input wire logic cs_n,
  input wire logic ctrl_serial_in,
  input wire logic [1:0] dev_sel,
  input wire reg_file_t rd_image,
  output logic ctrl_serial_out,
  output logic sdo_oe,
  output logic commit,
  output wr_word_t wr_word
);

  link_state_t st;
  link_state_t next_st;
  link_out_t out;
  link_out_t next_out;
  logic [6:0] hdr_addr;

  always_comb begin
    next_st = st;
    hdr_addr = {st.shift[5:0], ctrl_serial_in};
    if (st.bit_cnt != `FRAME_BITS) begin
      next_st.shift = {st.shift[6:0], ctrl_serial_in};
      next_st.bit_cnt = st.bit_cnt + 5'd1;
    end
    if (st.bit_cnt == `HDR_LAST) begin
      next_st.rw = st.shift[6];
      next_st.hit = (hdr_addr[`ADDR_DEV_HI:`ADDR_DEV_LO] == dev_sel);
      next_st.reg_idx = hdr_addr[`ADDR_REG_HI:0];
    end
    if (st.bit_cnt == `FRAME_LAST && !st.rw && st.hit) begin
      next_st.commit = 1'b1;
    end
  end

  // Raised chip select clears the frame, so each access needs a new fall
  always_ff @(posedge ctrl_clk or posedge cs_n) begin
    if (cs_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Write word survives chip select so the system side can still take it
  always_ff @(posedge ctrl_clk) begin
    if (!cs_n && st.bit_cnt == `FRAME_LAST && !st.rw && st.hit) begin
      wr_word <= '{addr: st.reg_idx, data: {st.shift[6:0], ctrl_serial_in}};
    end
  end

  always_comb begin
    next_out = out;
    if (st.bit_cnt == `HDR_BITS && st.rw && st.hit && !out.oe) begin
      next_out.oe = 1'b1;
      next_out.ctrl_serial_out = rd_image[st.reg_idx][7];
      next_out.out_shift = {rd_image[st.reg_idx][6:0], 1'b0};
    end else if (out.oe && st.bit_cnt != `FRAME_BITS) begin
      next_out.ctrl_serial_out = out.out_shift[7];
      next_out.out_shift = {out.out_shift[6:0], 1'b0};
    end
  end

  always_ff @(negedge ctrl_clk or posedge cs_n) begin
    if (cs_n) begin
      out <= '0;
    end else begin
      out <= next_out;
    end
  end

  assign ctrl_serial_out = out.ctrl_serial_out;
  assign sdo_oe = out.oe;
  assign commit = st.commit;

  a_no_drive_hdr: assert property (@(posedge ctrl_clk) disable iff (cs_n)
    st.bit_cnt <= `HDR_LAST |-> !out.oe)
    else $error("serial output driven before the address was complete");

  a_write_quiet: assert property (@(posedge ctrl_clk) disable iff (cs_n)
    st.bit_cnt >= `HDR_BITS && !st.rw |-> !out.oe)
    else $error("serial output driven during a write");

  // The host stops the clock after the sixteenth rise, so only a falling edge follows it
  a_commit_at_16: assert property (@(negedge ctrl_clk) disable iff (cs_n)
    $rose(st.commit) |-> st.bit_cnt == `FRAME_BITS && $past(st.bit_cnt) == `FRAME_LAST)
    else $error("write committed at the wrong bit count");

endmodule : ctrl_serial_port

// [hw/pin_sync.sv]
/*
  Two-stage synchroniser for a bundle of static or slow pins.
  Assumes each bit is an independent level; no word coherence is given.
*/
`timescale 1ns/1ns
module pin_sync
  import xcvr_mode_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire pins_t din,
  output pins_t dout
);

  typedef struct packed {
    pins_t meta;
    pins_t stable;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.meta = din;
    next_st.stable = st.meta;
  end

  // Chip select idles high so a frame is never seen during reset
  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
      st.meta.cs_n <= 1'b1;
      st.stable.cs_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.stable;

endmodule : pin_sync

// [hw/xcvr_mode_ctrl.sv]
/*
  Mode control and serial control port of a 155 Mbps line transceiver:
  pin decode in hardware mode, a sixteen-register file reached over the
  serial port in either mode and read by software mode, and the resulting configuration bundle.
  Assumes the analog line, equalizer, PLL and system datapaths read CONFIG,
  and that STATUS_IN comes from logic on CLOCK.
*/
// What this block does
// - Line select low: fiber NRZ, coded-mark-inversion buffers and equalizer off.
// - Line select high: coded-mark-inversion toward coax, NRZ buffers off.
// - Hardware mode, width pin high: byte-wide parallel system interface, serial pins idle.
// - Hardware mode, width pin low: serial differential interface, parallel pins idle.
// - Hardware serial coax with trim enabled: amplitude from the four-bit pin code.
// - Config select high: configuration comes from serially written registers.
// - Every access starts on a fresh falling edge of chip select.
// - A frame is read/write bit, seven address bits, eight data bits.
// - First bit high: the addressed register is shifted out serially.
// - First bit low: data captured, serial output stays released throughout.
// - Inputs sampled on rising serial clock, outputs change on falling.
// - Chip select rising ends a frame; short frames have no effect.
// - On reads the output stays released until address bit zero is in.
// - Parallel system interface moves one byte per clock at 19.44 MHz.
// - Serial system interface moves one bit per clock at 155.52 Mbps.
// - Both loopbacks can be chosen from pins or from registers.
// - Remote loopback centres the receive PLL on the crystal reference.
// - Local loopback feeds transmit line back to receive, transmit stays active.
// - Remote loopback turns received data back, system outputs stay active.
// - Only frames whose top address bits match the select pins complete.
// - Config select low: stand-alone pin-configured mode, serial port still writes registers that the configuration ignores.
// - Loop pins: both low normal, near alone local, far alone remote.
`timescale 1ns/1ns
`include "xcvr_mode_regs.svh"
module xcvr_mode_ctrl
  import xcvr_mode_pkg::*;
(
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic PIN_OR_REGISTER_CONFIG_SEL,
  input wire logic LINE_MEDIUM_SEL,
  input wire logic IFACE_WIDTH_SELECT,
  input wire logic AMP_ADJUST_ENABLE,
  input wire logic [3:0] AMP_ADJUST_CODE,
  input wire logic FAR_LOOP_PIN,
  input wire logic NEAR_LOOP_PIN,
  input wire logic DEV_SELECT_HI_PIN,
  input wire logic DEV_SELECT_LO_PIN,
  input wire logic CTRL_SERIAL_CLK,
  input wire logic CTRL_SERIAL_CS_N,
  input wire logic CTRL_SERIAL_IN,
  input wire logic [7:0] STATUS_IN,
  output logic CTRL_SERIAL_OUT,
  output logic CTRL_SERIAL_OUT_EN,
  output cfg_t CONFIG,
  output reg_file_t REG_FILE
);

  pins_t raw_pins;
  pins_t pins;
  logic link_commit;
  wr_word_t wr_word;
  reg_file_t rd_image;
  sys_state_t st;
  sys_state_t next_st;
  logic wr_event;

  function automatic reg_file_t default_regs();
    reg_file_t r;
    r = '{default: `RST_OTHER};
    r[`REG_PRIMARY] = `RST_PRIMARY;
    r[`REG_TX_CTRL] = `RST_TX_CTRL;
    r[`REG_TX_PLL1] = `RST_TX_PLL1;
    r[`REG_TX_PLL2] = `RST_TX_PLL2;
    r[`REG_EQ_LOAD] = `RST_EQ_LOAD;
    return r;
  endfunction : default_regs

  // Pin or register source for every mode the datapaths need
  function automatic cfg_t decode_cfg(input pins_t p, input reg_file_t r);
    cfg_t c;
    logic [7:0] pri;
    logic [7:0] txc;
    pri = r[`REG_PRIMARY];
    txc = r[`REG_TX_CTRL];
    c = '0;
    c.sw_mode = p.cfg_sel_sw;
    if (p.cfg_sel_sw) begin
      c.line_cmi = pri[`PRI_MEDIA_CMI];
      c.parallel_if = pri[`PRI_SYS_PARALLEL];
      c.rx_in_from_tx = pri[`PRI_LOCAL_LOOP];
      c.tx_in_from_rx = pri[`PRI_REMOTE_LOOP];
      c.amp_trim_on = 1'b1;
      c.amp_code = txc[`TXC_TRIM_HI:`TXC_TRIM_LO];
      c.tx_line_en = txc[`TXC_OUT_ENA];
      c.pll_ref_xtal = pri[`PRI_PLL_REF];
    end else begin
      c.line_cmi = p.medium_cmi;
      c.parallel_if = p.width_par;
      c.rx_in_from_tx = p.near_loop && !p.far_loop;
      c.tx_in_from_rx = p.far_loop && !p.near_loop;
      c.amp_trim_on = !p.width_par && p.medium_cmi && p.trim_en;
      c.amp_code = c.amp_trim_on ? p.trim_code : `AMP_NOMINAL;
      c.tx_line_en = 1'b1;
      c.pll_ref_xtal = 1'b0;
    end
    // Looping the recovered clock into its own reference would let it run away
    if (c.tx_in_from_rx) begin
      c.pll_ref_xtal = 1'b1;
    end
    c.nrz_buf_en = !c.line_cmi;
    c.cmi_buf_en = c.line_cmi;
    c.eq_en = c.line_cmi;
    // Byte-wide at the parallel clock, bit-serial at line rate otherwise
    c.par_pins_en = c.parallel_if;
    c.ser_pins_en = !c.parallel_if;
    // Loopbacks never silence the outputs they run beside
    c.sys_out_en = 1'b1;
    return c;
  endfunction : decode_cfg

  always_comb begin
    raw_pins = '0;
    raw_pins.commit = link_commit;
    raw_pins.cs_n = CTRL_SERIAL_CS_N;
    raw_pins.cfg_sel_sw = PIN_OR_REGISTER_CONFIG_SEL;
    raw_pins.medium_cmi = LINE_MEDIUM_SEL;
    raw_pins.width_par = IFACE_WIDTH_SELECT;
    raw_pins.trim_en = AMP_ADJUST_ENABLE;
    raw_pins.trim_code = AMP_ADJUST_CODE;
    raw_pins.far_loop = FAR_LOOP_PIN;
    raw_pins.near_loop = NEAR_LOOP_PIN;
    raw_pins.dev_sel = {DEV_SELECT_HI_PIN, DEV_SELECT_LO_PIN};
  end

  pin_sync u_pin_sync (
    .clk(CLOCK),
    .rst(SYS_RST),
    .din(raw_pins),
    .dout(pins)
  );

  // Status is frozen while a frame is open so a read shifts out one coherent byte
  always_comb begin
    rd_image = st.regs;
    rd_image[`REG_STATUS] = st.status_snap;
  end

  // Device select is a board strap, steady long before any frame starts
  ctrl_serial_port u_ctrl_serial_port (
    .ctrl_clk(CTRL_SERIAL_CLK),
    .cs_n(CTRL_SERIAL_CS_N),
    .ctrl_serial_in(CTRL_SERIAL_IN),
    .dev_sel(pins.dev_sel),
    .rd_image(rd_image),
    .ctrl_serial_out(CTRL_SERIAL_OUT),
    .sdo_oe(CTRL_SERIAL_OUT_EN),
    .commit(link_commit),
    .wr_word(wr_word)
  );

  // Commit rises once per completed write; the word is stable by then
  assign wr_event = pins.commit && !st.commit_seen;

  always_comb begin
    next_st = st;
    next_st.commit_seen = pins.commit;
    if (pins.cs_n) begin
      next_st.status_snap = STATUS_IN;
    end
    if (wr_event && wr_word.addr != `REG_STATUS) begin
      next_st.regs[wr_word.addr] = wr_word.data;
      if (wr_word.addr == `REG_RESET_BIAS && !wr_word.data[`RB_INIT]) begin
        next_st.regs = default_regs();
        next_st.regs[`REG_RESET_BIAS] = wr_word.data;
      end
    end
    next_st.cfg = decode_cfg(pins, st.regs);
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      st <= '0;
      st.regs <= default_regs();
      st.cfg <= decode_cfg('0, default_regs());
    end else begin
      st <= next_st;
    end
  end

  assign CONFIG = st.cfg;
  assign REG_FILE = st.regs;

  sequence s_plain_write;
    wr_event && wr_word.addr != `REG_STATUS && wr_word.addr != `REG_RESET_BIAS;
  endsequence

  sequence s_init_write;
    wr_event && wr_word.addr == `REG_RESET_BIAS && !wr_word.data[`RB_INIT];
  endsequence

  sequence s_hw_trim;
    !pins.cfg_sel_sw && !pins.width_par && pins.medium_cmi && pins.trim_en;
  endsequence

  property p_write_lands;
    @(posedge CLOCK) disable iff (SYS_RST)
      s_plain_write |=> st.regs[$past(wr_word.addr)] == $past(wr_word.data);
  endproperty

  a_write_lands: assert property (p_write_lands)
    else $error("written byte did not land in the register file");

  a_status_ro: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    wr_event && wr_word.addr == `REG_STATUS |=> $stable(st.regs))
    else $error("read-only status register was written");

  a_init_reload: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    s_init_write |=> st.regs[`REG_PRIMARY] == `RST_PRIMARY
      && st.regs[`REG_TX_CTRL] == `RST_TX_CTRL)
    else $error("init write did not restore defaults");

  a_one_write_each: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    wr_event |=> !wr_event [*2])
    else $error("one frame produced more than one write");

  a_media_bufs: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    CONFIG.line_cmi |-> CONFIG.cmi_buf_en && CONFIG.eq_en && !CONFIG.nrz_buf_en)
    else $error("coax mode left NRZ buffers on");

  a_media_nrz: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    !CONFIG.line_cmi |-> !CONFIG.cmi_buf_en && !CONFIG.eq_en && CONFIG.nrz_buf_en)
    else $error("fiber mode left coded-mark-inversion blocks on");

  a_hw_medium: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    !pins.cfg_sel_sw |=> CONFIG.line_cmi == $past(pins.medium_cmi)
      && CONFIG.parallel_if == $past(pins.width_par))
    else $error("hardware mode ignored the pins");

  a_width_pins: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    CONFIG.par_pins_en != CONFIG.ser_pins_en && CONFIG.par_pins_en == CONFIG.parallel_if)
    else $error("parallel and serial system pins enabled together");

  a_sw_from_regs: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    pins.cfg_sel_sw |=> CONFIG.parallel_if == $past(st.regs[`REG_PRIMARY][`PRI_SYS_PARALLEL])
      && CONFIG.line_cmi == $past(st.regs[`REG_PRIMARY][`PRI_MEDIA_CMI]))
    else $error("software mode ignored the primary control register");

  a_hw_trim: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    s_hw_trim |=> CONFIG.amp_code == $past(pins.trim_code) && CONFIG.amp_trim_on)
    else $error("amplitude code not taken from the trim pins");

  a_hw_no_trim: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    !pins.cfg_sel_sw && !pins.trim_en |=> CONFIG.amp_code == `AMP_NOMINAL)
    else $error("amplitude trimmed without enable");

  a_loop_pins: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    !pins.cfg_sel_sw && pins.near_loop == pins.far_loop
      |=> !CONFIG.rx_in_from_tx && !CONFIG.tx_in_from_rx)
    else $error("loopback selected with loop pins equal");

  a_remote_xtal: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    CONFIG.tx_in_from_rx |-> CONFIG.pll_ref_xtal && CONFIG.sys_out_en)
    else $error("remote loopback without crystal reference");

  a_local_tx_on: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    !pins.cfg_sel_sw && pins.near_loop |=> CONFIG.tx_line_en)
    else $error("local loopback silenced the line transmitter");

  a_snap_frozen: assert property (@(posedge CLOCK) disable iff (SYS_RST)
    !pins.cs_n [*2] |-> $stable(st.status_snap))
    else $error("status snapshot moved during a frame");

endmodule : xcvr_mode_ctrl

// [shared/xcvr_mode_pkg.sv]
/*
  Types of the transceiver mode and control-port block.
  Assumes the constants header is compiled alongside.
*/
package xcvr_mode_pkg;

  // Configuration pins after synchronisation, plus the link commit level
  typedef struct packed {
    logic commit;
    logic cs_n;
    logic cfg_sel_sw;
    logic medium_cmi;
    logic width_par;
    logic trim_en;
    logic [3:0] trim_code;
    logic far_loop;
    logic near_loop;
    logic [1:0] dev_sel;
  } pins_t;

  // Effective configuration handed to the line and system datapaths
  typedef struct packed {
    logic sw_mode;
    logic line_cmi;
    logic nrz_buf_en;
    logic cmi_buf_en;
    logic eq_en;
    logic parallel_if;
    logic par_pins_en;
    logic ser_pins_en;
    logic amp_trim_on;
    logic [3:0] amp_code;
    logic tx_line_en;
    logic sys_out_en;
    logic rx_in_from_tx;
    logic tx_in_from_rx;
    logic pll_ref_xtal;
  } cfg_t;

  typedef logic [15:0][7:0] reg_file_t;

  // Serial port state on rising serial clock edges
  typedef struct packed {
    logic [4:0] bit_cnt;
    logic [7:0] shift;
    logic rw;
    logic hit;
    logic [3:0] reg_idx;
    logic commit;
  } link_state_t;

  // Serial port output state on falling serial clock edges
  typedef struct packed {
    logic oe;
    logic ctrl_serial_out;
    logic [7:0] out_shift;
  } link_out_t;

  // Completed write, held stable until the next completed write
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] data;
  } wr_word_t;

  typedef struct packed {
    reg_file_t regs;
    logic [7:0] status_snap;
    logic commit_seen;
    cfg_t cfg;
  } sys_state_t;

endpackage : xcvr_mode_pkg

// [shared/xcvr_mode_regs.svh]
/*
  Offsets, field positions, reset values and frame counts of the transceiver
  mode and control-port block. Assumes it is included by bare name only.
*/
`ifndef XCVR_MODE_REGS_SVH
`define XCVR_MODE_REGS_SVH

// Register indices carried by address bits 3..0
`define REG_PRIMARY 4'h0
`define REG_TX_CTRL 4'h1
`define REG_TX_PLL1 4'h2
`define REG_TX_PLL2 4'h3
`define REG_EQ_LOAD 4'h4
`define REG_RESET_BIAS 4'hb
`define REG_STATUS 4'hf

// Primary control fields
`define PRI_LOCAL_LOOP 7
`define PRI_REMOTE_LOOP 6
`define PRI_PLL_REF 5
`define PRI_SYS_PARALLEL 1
`define PRI_MEDIA_CMI 0

// Transmit control fields
`define TXC_OUT_ENA 7
`define TXC_TRIM_HI 4
`define TXC_TRIM_LO 1

// Reset-and-bias field that reloads the defaults when written low
`define RB_INIT 6

// Reset values
`define RST_PRIMARY 8'h0c
`define RST_TX_CTRL 8'hcf
`define RST_TX_PLL1 8'h65
`define RST_TX_PLL2 8'he2
`define RST_EQ_LOAD 8'h01
`define RST_OTHER 8'h00

// Line amplitude code used when trim is not enabled
`define AMP_NOMINAL 4'h7

// Serial frame: count of rising clock edges
`define FRAME_BITS 5'd16
`define FRAME_LAST 5'd15
`define HDR_BITS 5'd8
`define HDR_LAST 5'd7

// Device-select address bits and register index bits
`define ADDR_DEV_HI 6
`define ADDR_DEV_LO 5
`define ADDR_REG_HI 3

`endif

// [verification/host_model.sv]
/*
  Host processor model that drives the four-wire serial control bus.
  Assumes the bench calls frame() while the system clock is out of reset.
*/
`timescale 1ns/1ns
module host_model (
  output logic sclk,
  output logic cs_n,
  output logic ctrl_serial_in,
  input wire logic ctrl_serial_out,
  input wire logic sdo_oe
);
  logic last = 1'b0;
  // Late rise gives the port's asynchronous clear a clean edge at start-up
  initial begin
    sclk = 1'b0;
    ctrl_serial_in = 1'b0;
    #1 cs_n = 1'b1;
  end
  // Serial clock stands still low outside frames; 80 ns period
  task automatic frame(input logic [15:0] word, input int nbits, input logic live,
                       output logic [7:0] rd, output logic oe_bad);
    logic w;
    rd = 8'h00;
    oe_bad = 1'b0;
    cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      ctrl_serial_in = word[15 - i];
      #40 sclk = 1'b1;
      // A released wire shows the inverse of its last value
      w = sdo_oe ? ctrl_serial_out : ~last;
      last = w;
      if (i >= 8) rd = {rd[6:0], w};
      if (sdo_oe !== (live && word[15] && i >= 8)) oe_bad = 1'b1;
      #40 sclk = 1'b0;
    end
    #20 cs_n = 1'b1;
    ctrl_serial_in = ~ctrl_serial_in;
    #120;
  endtask : frame
endmodule : host_model

// [verification/tb_top.sv]
/*
  Self-checking bench of the transceiver mode and control-port block.
  Assumes the host model drives the serial bus in its own clock domain.
*/
`timescale 1ns/1ns
`include "xcvr_mode_regs.svh"
module tb_top
  import xcvr_mode_pkg::*;
;
  logic CLOCK = 1'b0;
  logic SYS_RST = 1'b1;
  logic sel = 1'b0;
  logic [4:0] pins = 5'h00;
  logic [3:0] code = 4'h0;
  logic [1:0] dev = 2'h0;
  logic [7:0] status = 8'h00;
  logic sclk, cs_n, ctrl_serial_in, ctrl_serial_out, sdo_oe;
  cfg_t cfg;
  reg_file_t regs;
  int err_total = 0;
  int cmp_count = 0;

  xcvr_mode_ctrl u_xcvr_mode_ctrl (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
    .PIN_OR_REGISTER_CONFIG_SEL(sel), .LINE_MEDIUM_SEL(pins[4]),
    .IFACE_WIDTH_SELECT(pins[3]), .AMP_ADJUST_ENABLE(pins[2]), .AMP_ADJUST_CODE(code),
    .FAR_LOOP_PIN(pins[1]), .NEAR_LOOP_PIN(pins[0]), .DEV_SELECT_HI_PIN(dev[1]),
    .DEV_SELECT_LO_PIN(dev[0]), .CTRL_SERIAL_CLK(sclk), .CTRL_SERIAL_CS_N(cs_n),
    .CTRL_SERIAL_IN(ctrl_serial_in), .STATUS_IN(status), .CTRL_SERIAL_OUT(ctrl_serial_out),
    .CTRL_SERIAL_OUT_EN(sdo_oe), .CONFIG(cfg), .REG_FILE(regs));

  host_model u_host_model (.sclk(sclk), .cs_n(cs_n), .ctrl_serial_in(ctrl_serial_in), .ctrl_serial_out(ctrl_serial_out), .sdo_oe(sdo_oe));

  initial begin
    forever #5 CLOCK = ~CLOCK;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
      err_total++;
    end
  endtask : cmp

  function automatic logic [15:0] view(input cfg_t c);
    return {c.amp_trim_on, c.sw_mode, c.line_cmi, c.nrz_buf_en, c.cmi_buf_en, c.eq_en,
            c.parallel_if,
            c.par_pins_en, c.ser_pins_en, c.amp_code, c.rx_in_from_tx, c.tx_in_from_rx,
            c.pll_ref_xtal};
  endfunction : view

  function automatic logic [15:0] hw_exp(input logic [4:0] v, input logic [3:0] c);
    logic m, w, t, f, n;
    {m, w, t, f, n} = v;
    return {t && !w && m, 1'b0, m, !m, m, m, w, w, !w, (t && !w && m) ? c : `AMP_NOMINAL,
            n && !f, f && !n, f && !n};
  endfunction : hw_exp

  // Software mode always trims from the transmit control register
  function automatic logic [15:0] sw_exp(input logic [7:0] r0, input logic [7:0] r1);
    return {2'b11, r0[0], !r0[0], r0[0], r0[0], r0[1], r0[1], !r0[1], r1[4:1], r0[7], r0[6],
            r0[6] | r0[5]};
  endfunction : sw_exp

  task automatic wait_clk(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask : wait_clk

  task automatic xfer(input logic rw, input logic [1:0] d, input logic [3:0] r,
                      input logic [7:0] data, input int nbits, input logic live,
                      output logic [7:0] rd);
    logic bad;
    u_host_model.frame({rw, d, 1'b0, r, data}, nbits, live, rd, bad);
    cmp({15'h0000, bad}, 16'h0000);
    wait_clk(8);
  endtask : xfer

  task automatic t_reset();
    cmp({8'h00, regs[0]}, {8'h00, `RST_PRIMARY});
    cmp({regs[1], regs[2]}, {`RST_TX_CTRL, `RST_TX_PLL1});
    cmp({regs[3], regs[4]}, {`RST_TX_PLL2, `RST_EQ_LOAD});
    cmp({regs[11], regs[15]}, 16'h0000);
    cmp(view(cfg), hw_exp(5'h00, 4'h0));
  endtask : t_reset

  task automatic t_hw_pins();
    for (int i = 0; i < 32; i++) begin
      @(posedge CLOCK);
      pins <= 5'(i);
      code <= 4'(i * 3);
      wait_clk(5);
      cmp(view(cfg), hw_exp(5'(i), 4'(i * 3)));
    end
  endtask : t_hw_pins

  task automatic t_sw_access();
    logic [7:0] rd;
    @(posedge CLOCK);
    sel <= 1'b1;
    status <= 8'ha5;
    wait_clk(5);
    xfer(1'b0, 2'h0, 4'hb, 8'h00, 16, 1'b1, rd);
    xfer(1'b0, 2'h0, 4'h1, 8'h5a, 16, 1'b1, rd);
    cmp({8'h00, regs[1]}, 16'h005a);
    xfer(1'b1, 2'h0, 4'h1, 8'h00, 16, 1'b1, rd);
    cmp({8'h00, rd}, 16'h005a);
    xfer(1'b1, 2'h0, 4'hf, 8'h00, 16, 1'b1, rd);
    cmp({8'h00, rd}, 16'h00a5);
  endtask : t_sw_access

  task automatic t_refused();
    logic [7:0] rd;
    xfer(1'b0, 2'h1, 4'h2, 8'h33, 16, 1'b0, rd);
    xfer(1'b1, 2'h2, 4'h2, 8'h00, 16, 1'b0, rd);
    xfer(1'b0, 2'h0, 4'h2, 8'h33, 15, 1'b1, rd);
    xfer(1'b0, 2'h0, 4'hf, 8'h77, 16, 1'b1, rd);
    cmp({regs[2], regs[15]}, {`RST_TX_PLL1, 8'h00});
    @(posedge CLOCK);
    dev <= 2'h3;
    wait_clk(5);
    xfer(1'b0, 2'h3, 4'h2, 8'h33, 16, 1'b1, rd);
    cmp({8'h00, regs[2]}, 16'h0033);
  endtask : t_refused

  task automatic t_reload();
    logic [7:0] rd;
    xfer(1'b0, 2'h3, 4'hb, 8'h00, 16, 1'b1, rd);
    cmp({regs[1], regs[2]}, {`RST_TX_CTRL, `RST_TX_PLL1});
  endtask : t_reload

  task automatic t_sw_cfg();
    logic [7:0] rd;
    // Pins moved away from their defaults must not matter in software mode
    @(posedge CLOCK);
    pins <= 5'h1d;
    xfer(1'b0, 2'h3, 4'h0, 8'h42, 16, 1'b1, rd);
    cmp(view(cfg), sw_exp(8'h42, `RST_TX_CTRL));
    cmp({14'h0000, cfg.sys_out_en, cfg.tx_line_en}, 16'h0003);
    xfer(1'b0, 2'h3, 4'h0, 8'h80, 16, 1'b1, rd);
    cmp(view(cfg), sw_exp(8'h80, `RST_TX_CTRL));
    cmp({15'h0000, cfg.tx_line_en}, 16'h0001);
    xfer(1'b0, 2'h3, 4'h0, 8'h21, 16, 1'b1, rd);
    cmp(view(cfg), sw_exp(8'h21, `RST_TX_CTRL));
  endtask : t_sw_cfg

  initial begin
    #200000;
    err_total++;
    tally_and_finish();
  end

  initial begin
    repeat (8) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    wait_clk(1);
    t_reset();
    t_hw_pins();
    t_sw_access();
    t_refused();
    t_reload();
    t_sw_cfg();
    tally_and_finish();
  end
endmodule : tb_top
